// >>> hw/isf_pkg.sv
package isf_pkg;
  localparam logic [15:0] ISF_FLAG_ADDR = 16'hFFA9;
  localparam logic [15:0] ISF_STAT_ADDR = 16'hFFAA;
  localparam logic [7:0] ISF_FLAG_RESET = 8'h00;
  localparam logic [7:0] ISF_STAT_RESET = 8'h00;
  localparam int ISF_FLAG_START_CLEAR_FLAG = 7;
  localparam int ISF_FLAG_BSY = 6;
  localparam int ISF_FLAG_INITIAL_START_PERMIT = 1;
  localparam int ISF_FLAG_RSV = 0;
  localparam int ISF_STAT_TRC = 3;
  localparam int ISF_STAT_ACK = 2;
  localparam int ISF_STAT_STD = 1;
  localparam int ISF_STAT_SPD = 0;
  localparam int ISF_EV_START = 0;
  localparam int ISF_EV_STOP = 1;
  localparam int ISF_EV_FIRST = 2;
  localparam int ISF_EV_NINTH = 3;
  localparam int ISF_EV_N = 4;
  localparam logic [3:0] ISF_BIT_FIRST = 4'h1;
  localparam logic [3:0] ISF_BIT_NINTH = 4'h9;
  localparam int ISF_SYNC_STAGES = 2;
  typedef enum logic {
    ISF_LS_IDLE = 1'b0,
    ISF_LS_XFER = 1'b1
  } isf_lstate_e;
endpackage

// >>> hw/isf_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface isf_evt_if;
  // Toggles mark events; the data bits stay put until the next toggle
  logic [3:0] ev_tgl;
  logic ack_low;
  logic addr_byte;
  logic after_addr;
  logic ninth_win;
  modport mon(output ev_tgl, ack_low, addr_byte, after_addr, ninth_win);
  modport sys(input ev_tgl, ack_low, addr_byte, after_addr, ninth_win);
endinterface
`default_nettype wire

// >>> hw/isf_xsync.sv
`timescale 1ns/100ps
`default_nettype none
module isf_xsync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> hw/isf_link_mon.sv
`timescale 1ns/100ps
`default_nettype none
module isf_link_mon
  import isf_pkg::*;
(
  input wire logic i_link_clock,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  isf_evt_if.mon evt
);
  logic [1:0] pins_s;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic past_addr;
  isf_lstate_e state;

  isf_xsync #(.W(2)) u_pin_sync (
    .i_clock(i_link_clock),
    .i_rst(i_rst),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire scl_high = scl_s & scl_d;
  wire start_det = scl_high & sda_d & ~sda_s;
  wire stop_det = scl_high & ~sda_d & sda_s;
  wire scl_rise = scl_s & ~scl_d & (state == ISF_LS_XFER);
  wire wrap = (bit_cnt == ISF_BIT_NINTH);
  wire [3:0] next_bit_cnt = wrap ? ISF_BIT_FIRST : bit_cnt + 4'h1;

  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= ISF_LS_IDLE;
      bit_cnt <= 4'h0;
      past_addr <= 1'b0;
    end else if (start_det) begin
      state <= ISF_LS_XFER;
      bit_cnt <= 4'h0;
      past_addr <= 1'b0;
    end else if (stop_det) begin
      state <= ISF_LS_IDLE;
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt <= next_bit_cnt;
      past_addr <= past_addr | wrap;
    end
  end

  // RULE19: edge-detected bus events
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      evt.ev_tgl <= 4'h0;
      evt.ack_low <= 1'b0;
      evt.addr_byte <= 1'b0;
      evt.after_addr <= 1'b0;
    end else begin
      evt.ev_tgl[ISF_EV_START] <= evt.ev_tgl[ISF_EV_START] ^ start_det;
      evt.ev_tgl[ISF_EV_STOP] <= evt.ev_tgl[ISF_EV_STOP] ^ stop_det;
      if (scl_rise && next_bit_cnt == ISF_BIT_FIRST) begin
        evt.addr_byte <= (bit_cnt == 4'h0);
        evt.after_addr <= wrap & ~past_addr;
        evt.ev_tgl[ISF_EV_FIRST] <= ~evt.ev_tgl[ISF_EV_FIRST];
      end
      // RULE3: ack bit sampled
      if (scl_rise && next_bit_cnt == ISF_BIT_NINTH) begin
        evt.ack_low <= ~sda_s;
        evt.ev_tgl[ISF_EV_NINTH] <= ~evt.ev_tgl[ISF_EV_NINTH];
      end
    end
  end

  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      evt.ninth_win <= 1'b0;
    end else begin
      evt.ninth_win <= (state == ISF_LS_XFER) && wrap && !start_det;
    end
  end
endmodule
`default_nettype wire

// >>> hw/isf_top.sv
// What this block does
// RULE1: Wait release in transmit mode at ninth clock cancels wait, clears tx, frees data.
// RULE2: Software releases transmit-mode waits by writing the shift register instead.
// RULE3: Ack flag sets when data is low at ninth clock rising edge.
// RULE4: Ack flag clears on stop, next first clock, leave request, disable, reset.
// RULE5: Start flag sets on start condition; marks the address period.
// RULE6: Start flag clears on stop, first clock after address, leave, disable, reset.
// RULE7: Stop flag sets on stop condition; bus is free.
// RULE8: Stop flag clears at address byte first clock, on disable, on reset.
// RULE9: Start-clear and bus-busy bits are read-only; others take bit and byte writes.
// RULE10: Software writes reservation and start-permit bits only while disabled.
// RULE11: Reset clears the flag register to zero.
// RULE12: Reservation bit decides reservation for start requests on a busy bus.
// RULE13: Start-permit bit sets the bus-busy value taken at enable.
// RULE14: Failed start with reservation off sets start-clear flag; new request clears.
// RULE15: Flag register stays readable while enabled.
// RULE16: Flag register takes single-bit and whole-byte accesses.
// RULE17: Busy sets on start or enable with permit 0; clears stop, disable, reset.
// RULE18: Permit 1 allows start after enable; permit 0 waits for a stop.
// RULE19: Flags update on the system clock from synchronised edge-detected samples.
`timescale 1ns/100ps
`default_nettype none
module isf_top
  import isf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_link_clock,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_sda_tx,
  output logic o_sda_out,
  output logic o_sda_en_n,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_unit_enable,
  input wire logic i_leave_comm,
  input wire logic i_wait_release,
  input wire logic i_wait_active,
  input wire logic i_tx_set,
  input wire logic i_start_request,
  input wire logic i_start_fail,
  output logic o_wait_cancel,
  output logic o_start_cancel,
  output logic o_reserve,
  output logic o_start_allowed,
  output logic o_tx_mode,
  output logic o_bus_busy
);
  isf_evt_if evt ();

  logic [ISF_EV_N:0] xs;
  logic [ISF_EV_N-1:0] tgl_q;
  logic en_q;
  logic ack_seen;
  logic start_seen;
  logic stop_seen;
  logic start_clear;
  logic init_permit;
  logic rsv_dis;
  logic wrel_tx_q;

  isf_link_mon u_mon (
    .i_link_clock(i_link_clock),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .evt(evt)
  );

  isf_xsync #(.W(ISF_EV_N + 1)) u_ev_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({evt.ninth_win, evt.ev_tgl}),
    .o_sync(xs)
  );

  // Bit writes take their value from data bit 0
  function automatic logic [7:0] apply_wr(input logic [7:0] old,
                                          input logic [7:0] wd,
                                          input logic bit_wr,
                                          input logic [2:0] sel);
    logic [7:0] res;
    res = old;
    if (bit_wr) begin
      res[sel] = wd[0];
    end else begin
      res = wd;
    end
    return res;
  endfunction

  // Data bits change on the same link edge as their toggle, two sync stages before it arrives here
  wire [ISF_EV_N-1:0] ev_hit = (xs[ISF_EV_N-1:0] ^ tgl_q);
  wire enabled = i_unit_enable;
  wire ev_start = ev_hit[ISF_EV_START] & enabled;
  wire ev_stop = ev_hit[ISF_EV_STOP] & enabled;
  wire ev_first = ev_hit[ISF_EV_FIRST] & enabled;
  wire ev_ninth = ev_hit[ISF_EV_NINTH] & enabled;
  wire ninth_win = xs[ISF_EV_N];
  wire en_rise = enabled & ~en_q;
  wire leave = i_leave_comm & enabled;
  wire flag_hit = (i_addr == ISF_FLAG_ADDR);
  wire stat_hit = (i_addr == ISF_STAT_ADDR);
  wire flag_wr = flag_hit & (i_wr | i_bit_wr);
  wire [7:0] flag_val = {start_clear, o_bus_busy, 4'h0,
                         init_permit, rsv_dis};
  wire [7:0] stat_val = {4'h0, o_tx_mode, ack_seen,
                         start_seen, stop_seen};
  wire [7:0] flag_new = apply_wr(flag_val, i_wdata, i_bit_wr, i_bit_sel);
  wire wrel_tx = i_wait_release & i_wait_active & o_tx_mode & ninth_win;
  wire req_busy = i_start_request & o_bus_busy & enabled;
  wire start_kill = rsv_dis & (req_busy | i_start_fail);
  wire [7:0] rd_mux = flag_hit ? flag_val :
                      stat_hit ? stat_val : 8'h00;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tgl_q <= '0;
      en_q <= 1'b0;
    end else begin
      tgl_q <= xs[ISF_EV_N-1:0];
      en_q <= enabled;
    end
  end

  // RULE4: ack clear terms; set wins
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_seen <= 1'b0;
    end else if (!enabled) begin
      ack_seen <= 1'b0;
    end else if (ev_ninth && evt.ack_low) begin
      // RULE3: ack flag set
      ack_seen <= 1'b1;
    end else if (ev_stop || ev_first || leave) begin
      ack_seen <= 1'b0;
    end
  end

  // RULE5: start flag set
  // RULE6: start flag clear terms
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      start_seen <= 1'b0;
    end else if (!enabled) begin
      start_seen <= 1'b0;
    end else if (ev_start) begin
      start_seen <= 1'b1;
    end else if (ev_stop || leave || (ev_first && evt.after_addr)) begin
      start_seen <= 1'b0;
    end
  end

  // RULE7: stop flag set
  // RULE8: stop flag clear terms
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stop_seen <= 1'b0;
    end else if (!enabled) begin
      stop_seen <= 1'b0;
    end else if (ev_stop) begin
      stop_seen <= 1'b1;
    end else if (ev_first && evt.addr_byte) begin
      stop_seen <= 1'b0;
    end
  end

  // RULE17: busy tracking
  // RULE13: permit picks busy at enable
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_bus_busy <= ISF_FLAG_RESET[ISF_FLAG_BSY];
    end else if (!enabled) begin
      o_bus_busy <= 1'b0;
    end else if (ev_start) begin
      o_bus_busy <= 1'b1;
    end else if (ev_stop) begin
      o_bus_busy <= 1'b0;
    end else if (en_rise) begin
      o_bus_busy <= ~init_permit;
    end
  end

  // RULE11: flag register reset
  // RULE9: only writable bits taken
  // RULE10: writes honoured only while disabled
  // RULE16: bit and byte writes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      init_permit <= ISF_FLAG_RESET[ISF_FLAG_INITIAL_START_PERMIT];
      rsv_dis <= ISF_FLAG_RESET[ISF_FLAG_RSV];
    end else if (flag_wr && !enabled) begin
      init_permit <= flag_new[ISF_FLAG_INITIAL_START_PERMIT];
      rsv_dis <= flag_new[ISF_FLAG_RSV];
    end else if (ev_start) begin
      init_permit <= 1'b0;
    end
  end

  // RULE14: start-clear flag, set wins
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      start_clear <= ISF_FLAG_RESET[ISF_FLAG_START_CLEAR_FLAG];
    end else if (start_kill) begin
      start_clear <= 1'b1;
    end else if (i_start_request) begin
      start_clear <= 1'b0;
    end
  end

  // RULE12: reserve or cancel a busy-bus start
  // RULE18: start allowed once bus free
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_start_cancel <= 1'b0;
      o_reserve <= 1'b0;
      o_start_allowed <= 1'b0;
    end else begin
      o_start_cancel <= start_kill;
      o_reserve <= req_busy & ~rsv_dis;
      o_start_allowed <= enabled & ~o_bus_busy;
    end
  end

  // RULE1: cancel first, tx mode drops a cycle later
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_wait_cancel <= 1'b0;
      wrel_tx_q <= 1'b0;
    end else begin
      o_wait_cancel <= i_wait_release & i_wait_active;
      wrel_tx_q <= wrel_tx;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_tx_mode <= ISF_STAT_RESET[ISF_STAT_TRC];
    end else if (!enabled) begin
      o_tx_mode <= 1'b0;
    end else if (i_tx_set) begin
      o_tx_mode <= 1'b1;
    end else if (ev_stop || leave || wrel_tx_q) begin
      o_tx_mode <= 1'b0;
    end
  end

  // Open drain: only a low bit in transmit mode pulls the line
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out <= 1'b1;
      o_sda_en_n <= 1'b1;
    end else begin
      o_sda_out <= i_sda_tx;
      o_sda_en_n <= ~(o_tx_mode & ~i_sda_tx);
    end
  end

  // RULE15: reads answer in any enable state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  ack_set_a: assert property (ev_ninth && evt.ack_low |=> ack_seen) // RULE3
    else $error("ack flag not set after low ninth bit");
  ack_clr_a: assert property ( // RULE4
    (ev_first || ev_stop || leave) && !ev_ninth |=> !ack_seen)
    else $error("ack flag not cleared");
  std_set_a: assert property (ev_start |=> start_seen && o_bus_busy) // RULE5
    else $error("start flag or busy not set on start");
  std_clr_a: assert property ( // RULE6
    ev_first && evt.after_addr && !ev_start |=> !start_seen)
    else $error("start flag not cleared after address");
  spd_set_a: assert property ( // RULE7
    ev_stop && !ev_start |=> stop_seen && !o_bus_busy ##1 !o_reserve)
    else $error("stop flag or busy wrong after stop");
  spd_clr_a: assert property ( // RULE8
    ev_first && evt.addr_byte && !ev_stop |=> !stop_seen)
    else $error("stop flag not cleared at address byte");
  flag_ro_a: assert property ( // RULE9
    flag_wr && enabled && en_q && !i_start_request && !i_start_fail
    && !ev_start && !ev_stop |=> $stable({start_clear, o_bus_busy}))
    else $error("read-only flag bits changed by write");
  start_clear_flag_set_a: assert property ( // RULE14
    req_busy && rsv_dis |=> o_start_cancel && start_clear)
    else $error("start-clear not set on refused start");
  busy_en_a: assert property ( // RULE13
    en_rise && !ev_start && !ev_stop |=> o_bus_busy == !$past(init_permit))
    else $error("busy value at enable wrong");
  wrel_seq_a: assert property ( // RULE1
    wrel_tx |=> o_wait_cancel ##1 (!o_tx_mode || $past(i_tx_set))
    ##1 (o_sda_en_n || o_tx_mode))
    else $error("wait release sequence in transmit wrong");
  dis_clr_a: assert property ( // RULE4
    !enabled |=> !ack_seen && !start_seen && !stop_seen && !o_bus_busy)
    else $error("flags not cleared while disabled");

  ack_cov_c: cover property (ev_ninth && evt.ack_low ##[1:50] ev_first);
  wrel_cov_c: cover property (wrel_tx ##2 !o_tx_mode);
  start_clear_flag_cov_c: cover property (start_kill ##1 start_clear);
  busy_cov_c: cover property (en_rise ##1 o_bus_busy);
endmodule
`default_nettype wire

// >>> sim/isf_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module isf_bus_model (
  input wire logic i_link_clock,
  output logic o_scl,
  output logic o_sda
);
  // Phase length in link periods; raise it for a slow peer
  int phase = 4;
  // Idle bus: both lines released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hold();
    repeat (phase) @(posedge i_link_clock);
  endtask
  // Only from idle or after a stop, so no false stop is made
  task automatic start_c();
    o_sda <= 1'b1;
    hold();
    o_sda <= 1'b0;
    hold();
  endtask
  // Data changes only while the clock line is low
  task automatic put_bit(input logic b);
    o_scl <= 1'b0;
    hold();
    o_sda <= b;
    hold();
    o_scl <= 1'b1;
    hold();
  endtask
  task automatic stop_c();
    put_bit(1'b0);
    o_sda <= 1'b1;
    hold();
  endtask
  task automatic byte_x(input logic ack);
    repeat (8) put_bit(1'b1);
    put_bit(ack);
  endtask
endmodule
`default_nettype wire

// >>> sim/isf_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module isf_top_tb_top;
  import isf_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b0;
  logic link_clk = 1'b0;
  logic i_sda_tx, i_wr, i_bit_wr, i_rd, i_unit_enable, i_leave_comm;
  logic i_wait_release, i_wait_active, i_tx_set, i_start_request;
  logic i_start_fail, o_sda_out, o_sda_en_n, o_wait_cancel;
  logic o_start_cancel, o_reserve, o_start_allowed, o_tx_mode, o_bus_busy;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [2:0] i_bit_sel;
  logic m_scl, m_sda;
  wire sda_line;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Open drain: the device pulls low only while its enable is low
  assign sda_line = m_sda & (o_sda_en_n | o_sda_out);
  always #2 i_clock = ~i_clock;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  isf_bus_model isf_bus_model_i (.i_link_clock(link_clk), .o_scl(m_scl),
    .o_sda(m_sda));
  isf_top isf_top_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_link_clock(link_clk), .i_scl(m_scl), .i_sda(sda_line),
    .i_sda_tx(i_sda_tx), .o_sda_out(o_sda_out), .o_sda_en_n(o_sda_en_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_bit_wr(i_bit_wr),
    .i_bit_sel(i_bit_sel), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_unit_enable(i_unit_enable), .i_leave_comm(i_leave_comm),
    .i_wait_release(i_wait_release), .i_wait_active(i_wait_active),
    .i_tx_set(i_tx_set), .i_start_request(i_start_request),
    .i_start_fail(i_start_fail), .o_wait_cancel(o_wait_cancel),
    .o_start_cancel(o_start_cancel), .o_reserve(o_reserve),
    .o_start_allowed(o_start_allowed), .o_tx_mode(o_tx_mode),
    .o_bus_busy(o_bus_busy));
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic wr_bit(input logic [2:0] s, input logic v);
    @(posedge i_clock);
    i_bit_wr <= 1'b1;
    i_addr <= ISF_FLAG_ADDR;
    i_bit_sel <= s;
    i_wdata <= {7'h00, v};
    @(posedge i_clock);
    i_bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk8(o_rdata, exp);
  endtask
  task automatic req(input logic exp_cancel, input logic exp_reserve);
    @(posedge i_clock);
    i_start_request <= 1'b1;
    @(posedge i_clock);
    i_start_request <= 1'b0;
    #1;
    chk1(o_start_cancel, exp_cancel);
    chk1(o_reserve, exp_reserve);
  endtask
  task automatic enable(input logic v);
    @(posedge i_clock);
    i_unit_enable <= v;
    repeat (4) @(posedge i_clock);
  endtask
  // Pin events need about three link periods to reach the flags
  task automatic settle();
    repeat (80) @(posedge i_clock);
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    {i_sda_tx, i_wr, i_bit_wr, i_rd, i_unit_enable, i_leave_comm} = '0;
    {i_wait_release, i_wait_active, i_tx_set, i_start_request} = '0;
    i_start_fail = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    i_bit_sel = 3'h0;
    // Real edge at time zero: the link domain sees no clock during reset
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(ISF_FLAG_ADDR, ISF_FLAG_RESET);
    rd(ISF_STAT_ADDR, ISF_STAT_RESET);
    wr(ISF_FLAG_ADDR, 8'hFF);
    rd(ISF_FLAG_ADDR, 8'h03);
    wr_bit(3'h1, 1'b0);
    rd(ISF_FLAG_ADDR, 8'h01);
    rd(16'h0000, 8'h00);
    enable(1'b1);
    chk1(o_bus_busy, 1'b1);
    chk1(o_start_allowed, 1'b0);
    wr(ISF_FLAG_ADDR, 8'h00);
    rd(ISF_FLAG_ADDR, 8'h41);
    req(1'b1, 1'b0);
    rd(ISF_FLAG_ADDR, 8'hC1);
    isf_bus_model_i.stop_c();
    settle();
    rd(ISF_STAT_ADDR, 8'h01);
    chk1(o_bus_busy, 1'b0);
    req(1'b0, 1'b0);
    rd(ISF_FLAG_ADDR, 8'h01);
    isf_bus_model_i.start_c();
    settle();
    rd(ISF_STAT_ADDR, 8'h03);
    chk1(o_bus_busy, 1'b1);
    isf_bus_model_i.phase = 7;
    isf_bus_model_i.byte_x(1'b0);
    isf_bus_model_i.phase = 4;
    settle();
    rd(ISF_STAT_ADDR, 8'h06);
    @(posedge i_clock);
    i_tx_set <= 1'b1;
    i_wait_active <= 1'b1;
    @(posedge i_clock);
    i_tx_set <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk1(o_tx_mode, 1'b1);
    chk1(o_sda_en_n, 1'b0);
    chk1(o_sda_out, 1'b0);
    i_wait_release <= 1'b1;
    @(posedge i_clock);
    i_wait_release <= 1'b0;
    #1;
    chk1(o_wait_cancel, 1'b1);
    @(posedge i_clock);
    #1;
    chk1(o_tx_mode, 1'b0);
    @(posedge i_clock);
    #1;
    chk1(o_sda_en_n, 1'b1);
    // later tx waits end by a shift write
    i_wait_active <= 1'b0;
    i_sda_tx <= 1'b1;
    isf_bus_model_i.byte_x(1'b0);
    settle();
    chk1(o_sda_out, 1'b1);
    rd(ISF_STAT_ADDR, 8'h04);
    @(posedge i_clock);
    i_leave_comm <= 1'b1;
    @(posedge i_clock);
    i_leave_comm <= 1'b0;
    repeat (3) @(posedge i_clock);
    rd(ISF_STAT_ADDR, 8'h00);
    isf_bus_model_i.stop_c();
    settle();
    enable(1'b0);
    rd(ISF_STAT_ADDR, 8'h00);
    wr(ISF_FLAG_ADDR, 8'h02);
    enable(1'b1);
    rd(ISF_FLAG_ADDR, 8'h02);
    chk1(o_start_allowed, 1'b1);
    isf_bus_model_i.start_c();
    settle();
    rd(ISF_FLAG_ADDR, 8'h40);
    req(1'b0, 1'b1);
    isf_bus_model_i.stop_c();
    settle();
    end_of_test();
  end
endmodule
`default_nettype wire
